// File: rtl/wext_cfg.svh
// Purpose: Offsets, field positions and reset values for the waveform extension.
// Assumes: Registers are reached over a plain byte-wide port with a 4-bit address.
// Notes:   Definitions only.
`ifndef WEXT_CFG_SVH
`define WEXT_CFG_SVH

// =====================================================================
// Register offsets
`define WX_CTRL_OFS      4'h0
`define WX_OVR_OFS       4'h1
`define WX_DTLS_BUF_OFS  4'h2
`define WX_DTHS_BUF_OFS  4'h3
`define WX_PAT_BUF_OFS   4'h4
`define WX_FAULT_OFS     4'h5
`define WX_STAT_OFS      4'h6
`define WX_MASK_OFS      4'h7
`define WX_DTLS_ACT_OFS  4'h8
`define WX_DTHS_ACT_OFS  4'h9
`define WX_PAT_ACT_OFS   4'hA

// =====================================================================
// Control register fields
`define WX_CTRL_DTI_EN   0
`define WX_CTRL_PG_EN    1
`define WX_CTRL_CHA_DIST 2
`define WX_CTRL_HALT_EN  3
`define WX_CTRL_UPD_REQ  4

// Fault register fields
`define WX_FAULT_EV_EN   0
`define WX_FAULT_CLR     1

// Status fields: fault flag, fault event, update done
`define WX_STAT_FAULT    0
`define WX_STAT_FEVT     1
`define WX_STAT_UPD      2

// =====================================================================
// Reset values
`define WX_CTRL_RST      8'h00
`define WX_OVR_RST       8'h00
`define WX_DT_RST        8'h00
`define WX_PAT_RST       8'h00
`define WX_MASK_RST      8'h00

`endif

// File: rtl/wext_pkg.sv
// Purpose: Shared types for the waveform extension.
// Assumes: Eight port pins, four compare channels.
// Notes:   Constants live in wext_cfg.svh.
package wext_pkg;

  // Byte of register data.
  typedef logic [7:0] byte_t;

  // Dead-time inserter phases.
  typedef enum logic [1:0] {
    DT_IDLE,
    DT_WAIT_LS,
    DT_WAIT_HS
  } dt_state_e;

endpackage : wext_pkg

// File: rtl/dead_time_inserter.sv
// Purpose: One dead-time inserter producing complementary low and high side outputs.
// Assumes: Waveform input is synchronous to ref_clk_i.
// Notes:   Dead time counts whole clock cycles; zero gives no gap.
`timescale 1ns/1ps
module dead_time_inserter (
  // Clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  // Waveform and settings
  input  wire logic        wave_i,
  input  wire logic [7:0]  dt_ls_i,
  input  wire logic [7:0]  dt_hs_i,
  // Outputs
  output logic             ls_o,
  output logic             hs_o,
  output logic             busy_o
);

  typedef struct packed {
    wext_pkg::dt_state_e st;
    logic [7:0]          cnt;
    logic                wave;
    logic                ls;
    logic                hs;
  } dti_s;

  dti_s s_q;
  dti_s s_d;

  // Break before make: on an edge both sides go off, wait the dead time, then turn one on; zero dead time switches in one step.
  always_comb begin
    s_d      = s_q;
    s_d.wave = wave_i;
    case (s_q.st)
      wext_pkg::DT_IDLE: begin
        if (wave_i != s_q.wave) begin
          s_d.ls = 1'b0;
          s_d.hs = 1'b0;
          if (wave_i) begin
            if (dt_ls_i == 8'h00) begin
              s_d.ls = 1'b1; // RQ13
            end else begin
              s_d.cnt = dt_ls_i - 8'h01; // RQ4
              s_d.st  = wext_pkg::DT_WAIT_LS;
            end
          end else begin
            if (dt_hs_i == 8'h00) begin
              s_d.hs = 1'b1; // RQ13
            end else begin
              s_d.cnt = dt_hs_i - 8'h01; // RQ4
              s_d.st  = wext_pkg::DT_WAIT_HS;
            end
          end
        end
      end
      wext_pkg::DT_WAIT_LS, wext_pkg::DT_WAIT_HS: begin
        if (wave_i != s_q.wave) begin
          s_d.st = wext_pkg::DT_IDLE;
          s_d.ls = 1'b0;
          s_d.hs = 1'b0;
          if (wave_i) begin
            s_d.cnt = dt_ls_i - 8'h01;
            s_d.st  = (dt_ls_i == 8'h00) ? wext_pkg::DT_IDLE : wext_pkg::DT_WAIT_LS;
            s_d.ls  = (dt_ls_i == 8'h00);
          end else begin
            s_d.cnt = dt_hs_i - 8'h01;
            s_d.st  = (dt_hs_i == 8'h00) ? wext_pkg::DT_IDLE : wext_pkg::DT_WAIT_HS;
            s_d.hs  = (dt_hs_i == 8'h00);
          end
        end else if (s_q.cnt == 8'h00) begin
          s_d.st = wext_pkg::DT_IDLE;
          s_d.ls = (s_q.st == wext_pkg::DT_WAIT_LS); // RQ2
          s_d.hs = (s_q.st == wext_pkg::DT_WAIT_HS); // RQ2
        end else begin
          s_d.cnt = s_q.cnt - 8'h01;
        end
      end
      default: s_d.st = wext_pkg::DT_IDLE;
    endcase
  end

  // State register.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= '{st: wext_pkg::DT_IDLE, cnt: 8'h00, wave: 1'b0, ls: 1'b0, hs: 1'b1};
    end else begin
      s_q <= s_d;
    end
  end

  assign ls_o   = s_q.ls;
  assign hs_o   = s_q.hs;
  assign busy_o = (s_q.st != wext_pkg::DT_IDLE);

  // The two sides are never on together.
  a_no_overlap: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // RQ2
    !(ls_o && hs_o)) else $error("Low and high side on together.");

  // A rise with nonzero low dead time holds both sides off next cycle.
  a_gap_on_rise: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // RQ2
    (!busy_o && $rose(wave_i) && dt_ls_i != 8'h00) |=> (!ls_o && !hs_o))
    else $error("No gap before low side turns on.");

endmodule : dead_time_inserter

// File: rtl/waveform_extension.sv
// Purpose: Waveform extension with dead time, pattern generator and fault unit.
// Assumes: Serves the first timer of one port; waveform inputs are on ref_clk_i.
// Notes:   Eight pins: even pins low side, odd pins high side of channels A..D.
`timescale 1ns/1ps
`include "wext_cfg.svh"

// =====================================================================
// What this block does
// RQ1: Any feature enabled splits outputs into pairs; pairs reach the pins only with dead time on and the pattern off.
// RQ2: Low side follows, high side inverted, gapped.
// RQ3: Four inserters, eight-bit dead time each.
// RQ4: Separate high and low dead times.
// RQ5: Dead times buffered, loaded at update point.
// RQ6: Optional timer halt during dead time.
// RQ7: Override only selected pins.
// RQ8: Pattern drives all pins together, buffered.
// RQ9: Optionally channel A onto every pin.
// RQ10: Pattern generator bypasses dead time.
// RQ11: Selected event disables outputs at once.
// RQ12: One instance per timer, own outputs only.
// RQ13: Dead time in clock cycles; zero none.
// RQ14: Fault latches until software clears; flagged.
module waveform_extension (
  // Clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       rst_n_i,
  // Register port
  input  wire logic [3:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  output logic      [7:0] reg_rdata_o,
  // Timer side
  input  wire logic [3:0] wave_i,
  input  wire logic       update_i,
  input  wire logic [7:0] port_normal_i,
  output logic            timer_halt_o,
  // Event system
  input  wire logic       fault_event_i,
  // Port pins and interrupt
  output logic      [7:0] pin_o,
  output logic            irq_o
);

  // =====================================================================
  // Reset release and state
  logic [1:0] rst_sync_q;
  logic       rst_n;

  // Reset is released through two flip-flops.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] ovr;
    logic [7:0] dt_ls_buf;
    logic [7:0] dt_hs_buf;
    logic [7:0] pat_buf;
    logic       fev_en;
    logic [7:0] dt_ls;
    logic [7:0] dt_hs;
    logic [7:0] pat;
    logic       upd_pend;
    logic [2:0] stat;
    logic [2:0] mask;
    logic [7:0] rdata;
    logic [7:0] pin;
    logic       halt;
    logic       irq;
  } regs_s;

  regs_s s_q;
  regs_s s_d;

  // =====================================================================
  // Dead-time inserters
  logic [3:0] ls;
  logic [3:0] hs;
  logic [3:0] busy;

  // One inserter for each compare channel.
  generate
    for (genvar ch = 0; ch < 4; ch++) begin : g_dti
      dead_time_inserter u_dti ( // RQ3
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n),
        .wave_i    (wave_i[ch]),
        .dt_ls_i   (s_q.dt_ls),
        .dt_hs_i   (s_q.dt_hs),
        .ls_o      (ls[ch]),
        .hs_o      (hs[ch]),
        .busy_o    (busy[ch])
      );
    end
  endgenerate

  // Decodes the register address into its read value.
  function automatic logic [7:0] read_mux(input regs_s r, input logic [3:0] a);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      `WX_CTRL_OFS:     v = r.ctrl;
      `WX_OVR_OFS:      v = r.ovr;
      `WX_DTLS_BUF_OFS: v = r.dt_ls_buf;
      `WX_DTHS_BUF_OFS: v = r.dt_hs_buf;
      `WX_PAT_BUF_OFS:  v = r.pat_buf;
      `WX_FAULT_OFS:    v = {7'h00, r.fev_en};
      `WX_STAT_OFS:     v = {5'h00, r.stat};
      `WX_MASK_OFS:     v = {5'h00, r.mask};
      `WX_DTLS_ACT_OFS: v = r.dt_ls;
      `WX_DTHS_ACT_OFS: v = r.dt_hs;
      `WX_PAT_ACT_OFS:  v = r.pat;
      default:          v = 8'h00;
    endcase
    return v;
  endfunction : read_mux

  // =====================================================================
  // Next-state logic
  logic       wr_ctrl;
  logic       wr_fault;
  logic       rd_stat;
  logic       upd_now;
  logic       any_en;
  logic [7:0] split;
  logic [2:0] ev;

  assign wr_ctrl  = reg_wr_i && (reg_addr_i == `WX_CTRL_OFS);
  assign wr_fault = reg_wr_i && (reg_addr_i == `WX_FAULT_OFS);
  assign rd_stat  = reg_rd_i && (reg_addr_i == `WX_STAT_OFS);
  assign upd_now  = update_i && s_q.upd_pend;
  assign any_en   = s_q.ctrl[`WX_CTRL_DTI_EN] | s_q.ctrl[`WX_CTRL_PG_EN];

  // Interleave channel pairs onto pins: low side even, high side odd.
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      split[2*i]   = ls[i];
      split[2*i+1] = hs[i];
    end
  end

  // Register writes, buffered loads, fault latch and pin mux.
  always_comb begin
    s_d       = s_q;
    s_d.rdata = reg_rd_i ? read_mux(s_q, reg_addr_i) : 8'h00;
    if (reg_wr_i) begin
      case (reg_addr_i)
        `WX_CTRL_OFS: begin
          s_d.ctrl = reg_wdata_i;
          s_d.ctrl[`WX_CTRL_UPD_REQ] = 1'b0;
        end
        `WX_OVR_OFS:      s_d.ovr       = reg_wdata_i;
        `WX_DTLS_BUF_OFS: s_d.dt_ls_buf = reg_wdata_i; // RQ5
        `WX_DTHS_BUF_OFS: s_d.dt_hs_buf = reg_wdata_i; // RQ5
        `WX_PAT_BUF_OFS:  s_d.pat_buf   = reg_wdata_i; // RQ8
        `WX_FAULT_OFS:    s_d.fev_en    = reg_wdata_i[`WX_FAULT_EV_EN];
        `WX_MASK_OFS:     s_d.mask      = reg_wdata_i[2:0];
        default:          s_d.ctrl      = s_q.ctrl;
      endcase
    end
    // A write with the update bit arms a load at the next timer update.
    if (wr_ctrl && reg_wdata_i[`WX_CTRL_UPD_REQ]) begin
      s_d.upd_pend = 1'b1;
    end else if (upd_now) begin
      s_d.upd_pend = 1'b0;
    end
    if (upd_now) begin
      s_d.dt_ls = s_q.dt_ls_buf; // RQ5
      s_d.dt_hs = s_q.dt_hs_buf; // RQ5
      s_d.pat   = s_q.pat_buf;   // RQ8
    end
    // Status: a read clears the event bits, a new event wins over the clear.
    ev = 3'b000;
    ev[`WX_STAT_FEVT] = s_q.fev_en && fault_event_i;
    ev[`WX_STAT_UPD]  = upd_now;
    if (rd_stat) begin
      s_d.stat[`WX_STAT_FEVT] = 1'b0;
      s_d.stat[`WX_STAT_UPD]  = 1'b0;
    end
    if (wr_fault && reg_wdata_i[`WX_FAULT_CLR]) begin
      s_d.stat[`WX_STAT_FAULT] = 1'b0; // RQ14
    end
    if (ev[`WX_STAT_FEVT]) begin
      s_d.stat[`WX_STAT_FAULT] = 1'b1; // RQ11
    end
    s_d.stat[2:1] = s_d.stat[2:1] | ev[2:1];
    s_d.irq  = |(s_d.stat & s_d.mask);
    s_d.halt = s_q.ctrl[`WX_CTRL_HALT_EN] && s_q.ctrl[`WX_CTRL_DTI_EN]
               && !s_q.ctrl[`WX_CTRL_PG_EN] && (|busy); // RQ6
    // Output mux.
    s_d.pin = port_normal_i;
    if (ev[`WX_STAT_FEVT] || s_q.stat[`WX_STAT_FAULT]) begin
      s_d.pin = 8'h00; // RQ11 RQ14
    end else if (s_q.ctrl[`WX_CTRL_PG_EN]) begin
      for (int p = 0; p < 8; p++) begin // RQ10
        if (s_q.ovr[p]) begin
          s_d.pin[p] = s_q.ctrl[`WX_CTRL_CHA_DIST] ? (wave_i[0] & s_q.pat[p])
                                                   : s_q.pat[p]; // RQ8 RQ9
        end
      end
    end else if (any_en) begin
      s_d.pin = (s_q.ovr & split) | (~s_q.ovr & port_normal_i); // RQ1 RQ7 RQ12
    end
  end

  // State register.
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '{ctrl: `WX_CTRL_RST, ovr: `WX_OVR_RST, dt_ls_buf: `WX_DT_RST,
               dt_hs_buf: `WX_DT_RST, pat_buf: `WX_PAT_RST, fev_en: 1'b0,
               dt_ls: `WX_DT_RST, dt_hs: `WX_DT_RST, pat: `WX_PAT_RST,
               upd_pend: 1'b0, stat: 3'b000, mask: 3'b000, rdata: 8'h00,
               pin: 8'h00, halt: 1'b0, irq: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata_o  = s_q.rdata;
  assign pin_o        = s_q.pin;
  assign timer_halt_o = s_q.halt;
  assign irq_o        = s_q.irq;

  // =====================================================================
  // Checks
  a_fault_kills_pins: assert property (@(posedge ref_clk_i) disable iff (!rst_n) // RQ11
    (s_q.fev_en && fault_event_i) |=> (pin_o == 8'h00)) else $error("Fault left pins on.");

  a_fault_holds: assert property (@(posedge ref_clk_i) disable iff (!rst_n) // RQ14
    (s_q.stat[`WX_STAT_FAULT] && !wr_fault) |=> s_q.stat[`WX_STAT_FAULT])
    else $error("Fault cleared without software.");

  a_buf_no_early: assert property (@(posedge ref_clk_i) disable iff (!rst_n) // RQ5
    !upd_now |=> $stable(s_q.dt_ls) && $stable(s_q.dt_hs)) else $error("Dead time changed early.");

  a_buf_load: assert property (@(posedge ref_clk_i) disable iff (!rst_n) // RQ8
    upd_now |=> (s_q.pat == $past(s_q.pat_buf))) else $error("Pattern not loaded.");

  a_no_override_off: assert property (@(posedge ref_clk_i) disable iff (!rst_n) // RQ1
    (!any_en && !s_q.stat[`WX_STAT_FAULT] && !fault_event_i)
    |=> (pin_o == $past(port_normal_i))) else $error("Pins altered while idle.");

  a_ovr_select: assert property (@(posedge ref_clk_i) disable iff (!rst_n) // RQ7
    (s_q.ctrl[`WX_CTRL_DTI_EN] && !s_q.ctrl[`WX_CTRL_PG_EN] && !s_q.stat[`WX_STAT_FAULT]
     && !fault_event_i) |=> ((pin_o & ~$past(s_q.ovr)) == ($past(port_normal_i) & ~$past(s_q.ovr))))
    else $error("Unselected pin overridden.");

  a_halt_only_dti: assert property (@(posedge ref_clk_i) disable iff (!rst_n) // RQ6
    !s_q.ctrl[`WX_CTRL_HALT_EN] |=> !timer_halt_o) else $error("Halt without setting.");

  a_pattern_bypass: assert property (@(posedge ref_clk_i) disable iff (!rst_n) // RQ10
    (s_q.ctrl[`WX_CTRL_PG_EN] && !s_q.ctrl[`WX_CTRL_CHA_DIST] && !s_q.stat[`WX_STAT_FAULT]
     && !fault_event_i) |=> ((pin_o & $past(s_q.ovr)) == ($past(s_q.pat) & $past(s_q.ovr))))
    else $error("Pattern not on pins.");

  a_irq_level: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    ##1 (irq_o == |(s_q.stat & s_q.mask))) else $error("Interrupt level wrong.");

  // =====================================================================
  // Checks on flags, buffers, register port and pin mux

  // A taken fault event latches the fault flag.
  a_fault_sets_flag: assert property (@(posedge ref_clk_i) disable iff (!rst_n) // RQ14
    (s_q.fev_en && fault_event_i) |=> s_q.stat[`WX_STAT_FAULT])
    else $error("Fault flag not set.");

  // A clear write with no new event drops the flag.
  a_fault_clears: assert property (@(posedge ref_clk_i) disable iff (!rst_n) // RQ14
    (wr_fault && reg_wdata_i[`WX_FAULT_CLR] && !(s_q.fev_en && fault_event_i))
    |=> !s_q.stat[`WX_STAT_FAULT]) else $error("Fault flag not cleared.");

  // A latched fault keeps every pin low.
  a_fault_pins_low: assert property (@(posedge ref_clk_i) disable iff (!rst_n) // RQ14
    s_q.stat[`WX_STAT_FAULT] |=> (pin_o == 8'h00)) else $error("Pins on in fault.");

  // Distribution puts wave A, gated by the pattern, on overridden pins.
  a_dist_pins: assert property (@(posedge ref_clk_i) disable iff (!rst_n) // RQ9
    (s_q.ctrl[`WX_CTRL_PG_EN] && s_q.ctrl[`WX_CTRL_CHA_DIST]
     && !s_q.stat[`WX_STAT_FAULT] && !fault_event_i)
    |=> ((pin_o & $past(s_q.ovr))
         == ({8{$past(wave_i[0])}} & $past(s_q.pat) & $past(s_q.ovr))))
    else $error("Channel A not distributed.");

  // Pattern mode never halts the timer.
  a_pattern_no_halt: assert property (@(posedge ref_clk_i) disable iff (!rst_n) // RQ10
    s_q.ctrl[`WX_CTRL_PG_EN] |=> !timer_halt_o) else $error("Halt in pattern mode.");

  // A counting inserter halts the timer when halting is chosen, dead time is on and the pattern is off.
  a_halt_on_dead: assert property (@(posedge ref_clk_i) disable iff (!rst_n) // RQ6
    (s_q.ctrl[`WX_CTRL_HALT_EN] && s_q.ctrl[`WX_CTRL_DTI_EN]
     && !s_q.ctrl[`WX_CTRL_PG_EN] && (|busy)) |=> timer_halt_o)
    else $error("Timer not halted.");

  // A load consumes the pending request.
  a_upd_consumed: assert property (@(posedge ref_clk_i) disable iff (!rst_n) // RQ5
    (upd_now && !(wr_ctrl && reg_wdata_i[`WX_CTRL_UPD_REQ])) |=> !s_q.upd_pend)
    else $error("Request not consumed.");

  // Dead times move from the buffers at the update point.
  a_dt_load: assert property (@(posedge ref_clk_i) disable iff (!rst_n) // RQ5
    upd_now |=> (s_q.dt_ls == $past(s_q.dt_ls_buf))
                && (s_q.dt_hs == $past(s_q.dt_hs_buf)))
    else $error("Dead times not loaded.");

  // The active pattern changes only at the update point.
  a_pat_no_early: assert property (@(posedge ref_clk_i) disable iff (!rst_n) // RQ8
    !upd_now |=> $stable(s_q.pat)) else $error("Pattern changed early.");

  // Read data stand only in the cycle after a read.
  a_rdata_idle: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    !reg_rd_i |=> (reg_rdata_o == 8'h00)) else $error("Read data without read.");

  // Unmapped places read as zero.
  a_unmapped_zero: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    (reg_rd_i && reg_addr_i > `WX_PAT_ACT_OFS) |=> (reg_rdata_o == 8'h00))
    else $error("Unmapped read nonzero.");

  // Dead-time pairs reach the overridden pins untouched.
  a_split_pins: assert property (@(posedge ref_clk_i) disable iff (!rst_n) // RQ1
    (s_q.ctrl[`WX_CTRL_DTI_EN] && !s_q.ctrl[`WX_CTRL_PG_EN]
     && !s_q.stat[`WX_STAT_FAULT] && !fault_event_i)
    |=> ((pin_o & $past(s_q.ovr)) == ($past(split) & $past(s_q.ovr))))
    else $error("Pair not on pins.");

  // A status read clears the event bits unless a new event lands.
  a_stat_rd_clear: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    (rd_stat && !(s_q.fev_en && fault_event_i) && !upd_now)
    |=> (s_q.stat[2:1] == 2'b00)) else $error("Status not cleared.");

  // The update request bit never stays set.
  a_upd_bit_zero: assert property (@(posedge ref_clk_i) disable iff (!rst_n) // RQ5
    !s_q.ctrl[`WX_CTRL_UPD_REQ]) else $error("Update bit stuck.");

  // The override mask changes only by a write to it.
  a_ovr_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_n) // RQ7
    !(reg_wr_i && reg_addr_i == `WX_OVR_OFS) |=> $stable(s_q.ovr))
    else $error("Override mask changed.");

  // With every status bit masked the interrupt stays low.
  a_irq_masked: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    (s_q.mask == 3'b000 && !(reg_wr_i && reg_addr_i == `WX_MASK_OFS)) |=> !irq_o)
    else $error("Masked interrupt raised.");

endmodule : waveform_extension

// File: tb/gate_driver_model.sv
// Purpose: Behavioural power stage behind the eight port pins.
// Assumes: Pin 2k drives the low side gate and pin 2k+1 the high side gate of leg k.
// Notes:   A commanded trip comes back one cycle later as a one-cycle fault pulse.
`timescale 1ns/1ps
module gate_driver_model (
  // Clock
  input  wire logic       ref_clk_i,
  // Gate drive and trip command
  input  wire logic [7:0] pin_i,
  input  wire logic       trip_i,
  // Fault pulse and shoot-through count
  output logic            fault_o,
  output logic      [7:0] overlap_o
);
  // =====================================================================
  // Leg monitor
  // A sensed trip is reported one cycle late, as a desaturation sensor would.
  // Both gates of one leg on at a sampling edge counts as a shoot-through.
  initial overlap_o = 8'h00;
  initial fault_o = 1'b0;
  always @(posedge ref_clk_i) begin
    fault_o <= trip_i;
    for (int k = 0; k < 4; k++) begin
      if (pin_i[2*k] === 1'b1 && pin_i[2*k+1] === 1'b1) begin
        overlap_o <= overlap_o + 8'h01;
      end
    end
  end
endmodule : gate_driver_model

// File: tb/waveform_extension_tb.sv
// Purpose: Self-checking bench for the waveform extension.
// Assumes: Register map and latencies as handed over with the design.
// Notes:   Power stage model counts shoot-through and raises faults.
`timescale 1ns/1ps
`include "wext_cfg.svh"
module waveform_extension_tb;
  logic       ref_clk_i = 1'b0;
  logic       rst_n_i = 1'b0;
  logic [3:0] reg_addr_i = 4'h0;
  logic [7:0] reg_wdata_i = 8'h00;
  logic       reg_wr_i = 1'b0;
  logic       reg_rd_i = 1'b0;
  logic [7:0] reg_rdata_o;
  logic [3:0] wave_i = 4'h0;
  logic       update_i = 1'b0;
  logic [7:0] port_normal_i = 8'h96;
  logic       timer_halt_o;
  logic       fault_event_i;
  logic [7:0] pin_o;
  logic       irq_o;
  logic       trip;
  logic [7:0] overlap;
  logic [7:0] rd;
  int         num_errors = 0;
  int         check_count = 0;
  int         cycles = 0;

  // =====================================================================
  // Clock, design and power stage
  always #5 ref_clk_i = ~ref_clk_i;
  initial trip = 1'b0;
  waveform_extension waveform_extension_i (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .wave_i(wave_i),
    .update_i(update_i), .port_normal_i(port_normal_i), .timer_halt_o(timer_halt_o),
    .fault_event_i(fault_event_i), .pin_o(pin_o), .irq_o(irq_o));
  gate_driver_model gate_driver_model_i (.ref_clk_i(ref_clk_i), .pin_i(pin_o),
    .trip_i(trip), .fault_o(fault_event_i), .overlap_o(overlap));

  // =====================================================================
  // Shared tasks
  // Compares one value and counts it.
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : chk

  // One-cycle write strobe.
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
  endtask : wr

  // One-cycle read strobe; data is taken in the following cycle only.
  task automatic rdr(input logic [3:0] a);
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
    #1;
    rd = reg_rdata_o;
  endtask : rdr

  // Requests a buffer load and gives the timer update point.
  task automatic do_update(input logic [7:0] ctrl);
    wr(`WX_CTRL_OFS, ctrl | 8'h10);
    @(posedge ref_clk_i);
    update_i <= 1'b1;
    @(posedge ref_clk_i);
    update_i <= 1'b0;
    @(posedge ref_clk_i);
  endtask : do_update

  // Moves wave A and measures when the new side of channel A turns on.
  task automatic dt_edge(input logic lvl, input int n);
    int   k;
    logic gap;
    logic halt;
    k = 0;
    gap = 1'b0;
    halt = 1'b0;
    @(posedge ref_clk_i);
    wave_i[0] <= lvl;
    do begin
      @(posedge ref_clk_i);
      #1;
      k++;
      if (pin_o[1:0] === 2'b00) gap = 1'b1;
      if (timer_halt_o === 1'b1) halt = 1'b1;
    end while (pin_o[lvl ? 0 : 1] !== 1'b1 && k < 300);
    chk(8'(k), 8'(n + 2), "turn-on delay");
    chk({7'h00, gap}, {7'h00, n > 0}, "dead gap");
    chk({7'h00, halt}, {7'h00, n > 0}, "timer halt");
    chk(pin_o[1:0], lvl ? 2'b01 : 2'b10, "pair levels");
    chk(pin_o[7:2], port_normal_i[7:2], "pins not overridden");
    @(posedge ref_clk_i);
    #1;
    chk({7'h00, timer_halt_o}, 8'h00, "halt released");
  endtask : dt_edge

  // =====================================================================
  // Scenarios
  // Reset values, unmapped and read-only places.
  task automatic t_regs();
    for (int a = 0; a < 12; a++) begin
      if (a != 5) begin
        rdr(4'(a));
        chk(rd, 8'h00, "reset value");
      end
    end
    wr(`WX_DTLS_ACT_OFS, 8'hFF);
    wr(4'hB, 8'hFF);
    rdr(`WX_DTLS_ACT_OFS);
    chk(rd, `WX_DT_RST, "read-only write");
    rdr(4'hB);
    chk(rd, 8'h00, "unmapped read");
    chk(pin_o, port_normal_i, "pins idle");
    $display("test regs done");
  endtask : t_regs

  // Buffered dead times, both edges, zero length and timer halt.
  task automatic t_dead();
    wr(`WX_DTLS_BUF_OFS, 8'h03);
    wr(`WX_DTHS_BUF_OFS, 8'h05);
    @(posedge ref_clk_i);
    update_i <= 1'b1;
    @(posedge ref_clk_i);
    update_i <= 1'b0;
    rdr(`WX_DTLS_ACT_OFS);
    chk(rd, 8'h00, "no load without request");
    rdr(`WX_DTLS_BUF_OFS);
    chk(rd, 8'h03, "buffer holds value");
    do_update(8'h09);
    rdr(`WX_DTLS_ACT_OFS);
    chk(rd, 8'h03, "low side active");
    rdr(`WX_DTHS_ACT_OFS);
    chk(rd, 8'h05, "high side active");
    wr(`WX_OVR_OFS, 8'h03);
    wr(`WX_CTRL_OFS, 8'h09);
    dt_edge(1'b1, 3);
    dt_edge(1'b0, 5);
    wr(`WX_DTLS_BUF_OFS, 8'h00);
    wr(`WX_DTHS_BUF_OFS, 8'hFF);
    do_update(8'h09);
    dt_edge(1'b1, 0);
    dt_edge(1'b0, 255);
    chk(overlap, 8'h00, "no shoot-through");
    $display("test dead time done");
  endtask : t_dead

  // Pattern output, its buffering and channel A distribution.
  task automatic t_pattern();
    wr(`WX_PAT_BUF_OFS, 8'hA5);
    wr(`WX_OVR_OFS, 8'hFF);
    wr(`WX_CTRL_OFS, 8'h0B);
    rdr(`WX_PAT_ACT_OFS);
    chk(rd, 8'h00, "pattern waits for update");
    do_update(8'h0B);
    #1;
    chk(pin_o, 8'hA5, "pattern on pins");
    @(posedge ref_clk_i);
    wave_i[0] <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    #1;
    chk(pin_o, 8'hA5, "no dead time in pattern");
    chk({7'h00, timer_halt_o}, 8'h00, "no halt in pattern");
    wr(`WX_CTRL_OFS, 8'h0F);
    repeat (2) @(posedge ref_clk_i);
    #1;
    chk(pin_o, 8'hA5, "channel A high distributed");
    @(posedge ref_clk_i);
    wave_i[0] <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    #1;
    chk(pin_o, 8'h00, "channel A low distributed");
    chk({7'h00, timer_halt_o}, 8'h00, "no halt on long dead time");
    $display("test pattern done");
  endtask : t_pattern

  // Fault shutdown, latching, flag, interrupt and clearing.
  task automatic t_fault();
    wr(`WX_CTRL_OFS, 8'h0B);
    rdr(`WX_STAT_OFS);
    wr(`WX_FAULT_OFS, 8'h01);
    wr(`WX_MASK_OFS, 8'h01);
    @(posedge ref_clk_i);
    trip <= 1'b1;
    @(posedge ref_clk_i);
    trip <= 1'b0;
    @(posedge ref_clk_i);
    #1;
    chk(pin_o, 8'h00, "fault shuts pins");
    repeat (2) @(posedge ref_clk_i);
    #1;
    chk({7'h00, irq_o}, 8'h01, "fault interrupt");
    rdr(`WX_STAT_OFS);
    chk(rd & 8'h03, 8'h03, "fault flags");
    rdr(`WX_STAT_OFS);
    chk(rd & 8'h03, 8'h01, "event bit read-cleared");
    chk(pin_o, 8'h00, "fault holds");
    wr(`WX_MASK_OFS, 8'h00);
    repeat (2) @(posedge ref_clk_i);
    #1;
    chk({7'h00, irq_o}, 8'h00, "masked interrupt");
    wr(`WX_FAULT_OFS, 8'h03);
    repeat (3) @(posedge ref_clk_i);
    #1;
    chk(pin_o, 8'hA5, "cleared fault releases");
    $display("test fault done");
  endtask : t_fault

  // =====================================================================
  // Closing report
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : test_done

  // Cuts a hang short.
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 6000) begin
      num_errors++;
      $display("[ERR] %0t timeout", $time);
      test_done();
    end
  end

  // Main sequence.
  initial begin
    repeat (10) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    t_regs();
    t_dead();
    t_pattern();
    t_fault();
    test_done();
  end
endmodule : waveform_extension_tb
